// file: hw/lcd_strap_sync.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lcd_strap_params.svh"
module lcd_strap_sync (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 parallel_select,
	input  wire logic                 osc_source_select,
	input  wire logic                 primary_select,
	input  wire logic                 internal_divider_select,
	input  wire logic                 duty_select_low,
	input  wire logic                 duty_select_high,
	input  wire logic                 display_clock_pin_i,
	output logic                      display_clock_pin_o,
	output logic                      display_clock_pin_oe,
	input  wire logic                 frame_alternation_signal_i,
	output logic                      frame_alternation_signal_o,
	output logic                      frame_alternation_signal_oe,
	input  wire logic                 display_blank_signal_n_i,
	output logic                      display_blank_signal_n_o,
	output logic                      display_blank_signal_n_oe,
	output logic                      data_low_oe,
	output logic                      ram_read_enable,
	output logic                      osc_enable,
	output logic                      internal_divider_enable,
	output logic                      static_indicator_drive,
	input  wire logic [131:0]         segment_pattern,
	output logic [131:0]              segment_outputs,
	output logic [31:0]               common_outputs_lower,
	output logic [31:0]               common_outputs_upper,
	output logic [1:0]                indicator_common_outputs,
	output lcd_strap_pkg::duty_t      duty_mode
);
	import lcd_strap_pkg::*;

	localparam int DIV_W = 9;

	// Last scan line index for a duty; the last line feeds the indicator
	function automatic line_t last_line(input duty_t d);
		case (d)
			duty_33: last_line = 7'd32;
			duty_49: last_line = 7'd48;
			duty_55: last_line = 7'd54;
			duty_65: last_line = 7'd64;
			default: last_line = 7'd32;
		endcase
	endfunction : last_line

	pin_sync_if #(.W(9)) pins ();
	pin_sync #(.W(9)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    (pins)
	);

	assign pins.raw = {display_blank_signal_n_i, frame_alternation_signal_i,
		display_clock_pin_i, duty_select_high, duty_select_low,
		internal_divider_select, primary_select, osc_source_select,
		parallel_select};

	logic  par;
	logic  osc_on;
	logic  primary;
	logic  int_div;
	duty_t duty;
	logic  clk_in;
	logic  fr_in;
	logic  blank_n_in;
	assign par        = pins.stable[0];
	assign osc_on     = pins.stable[1];
	assign primary    = pins.stable[2];
	assign int_div    = pins.stable[3];
	assign duty       = duty_t'(pins.stable[5:4]);
	assign clk_in     = pins.stable[6];
	assign fr_in      = pins.stable[7];
	assign blank_n_in = pins.stable[8];

	logic [31:0]      ctrl_q;
	logic             wr_addr_ok;
	logic [11:0]      awaddr_q;
	logic             aw_have_q;
	logic [31:0]      wdata_q;
	logic [3:0]       wstrb_q;
	logic             w_have_q;
	rd_state_t        rd_state_q;
	logic [DIV_W-1:0] div_q;
	logic             clk_out_q;
	logic             clk_in_d1_q;
	logic             fr_in_d1_q;
	line_t            line_q;
	logic             fr_q;
	logic             disp_en;
	logic             tick;

	// AXI write: address and data taken independently, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			awaddr_q  <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
		end
	end

	assign wr_addr_ok = (awaddr_q == `OFF_CTRL) ||
		(awaddr_q == `OFF_STATUS) || (awaddr_q == `OFF_SCAN);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			ctrl_q       <= `CTRL_RESET_VAL;
		end else if (s_axi_bvalid) begin
			if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end else if (aw_have_q && w_have_q) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_addr_ok ? `RESP_OKAY : `RESP_DECERR;
			if (awaddr_q == `OFF_CTRL && wstrb_q[0]) begin
				ctrl_q[1:0] <= wdata_q[1:0];
			end
		end
	end

	// AXI read: one outstanding read, data registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q    <= rd_idle;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			case (rd_state_q)
				rd_idle: begin
					s_axi_arready <= 1'b1;
					if (s_axi_arvalid && s_axi_arready) begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rresp   <= `RESP_OKAY;
						rd_state_q    <= rd_resp;
						case (s_axi_araddr)
							`OFF_CTRL:   s_axi_rdata <= ctrl_q;
							`OFF_STATUS: s_axi_rdata <= {24'h000000, fr_q,
								disp_en, duty, int_div, primary, osc_on, par};
							`OFF_SCAN:   s_axi_rdata <= {23'h000000, fr_q,
								1'b0, line_q};
							default: begin
								s_axi_rdata <= 32'h0000_0000;
								s_axi_rresp <= `RESP_DECERR;
							end
						endcase
					end
				end
				rd_resp: begin
					s_axi_arready <= 1'b0;
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state_q   <= rd_idle;
					end
				end
				default: rd_state_q <= rd_idle;
			endcase
		end
	end

	// internal oscillator only with clock source strap high
	always_ff @(posedge aclk) begin
		if (!aresetn || !osc_on) begin
			div_q     <= '0;
			clk_out_q <= 1'b0;
		end else if (div_q == DIV_W'(`DISP_CLK_HALF_CYC - 1)) begin
			div_q     <= '0;
			clk_out_q <= !clk_out_q;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// external clock edges found on the sampled pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_in_d1_q <= 1'b0;
			fr_in_d1_q  <= 1'b0;
		end else begin
			clk_in_d1_q <= clk_in;
			fr_in_d1_q  <= fr_in;
		end
	end

	// Pin driven only by an oscillating primary, so counting follows the pin
	assign tick = clk_in && !clk_in_d1_q;
	// secondary takes blanking from the shared pin
	assign disp_en = primary ? ctrl_q[`CTRL_DISP_ON] : blank_n_in;

	// primary counts lines, secondary realigns on frame edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_q <= 7'd0;
			fr_q   <= 1'b0;
		end else if (!primary && (fr_in != fr_in_d1_q)) begin
			line_q <= 7'd0;
			fr_q   <= fr_in;
		end else if (tick) begin
			if (line_q >= last_line(duty)) begin
				line_q <= 7'd0;
				if (primary) begin
					fr_q <= !fr_q;
				end
			end else begin
				line_q <= line_q + 7'd1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			display_clock_pin_o         <= 1'b0;
			display_clock_pin_oe        <= 1'b0;
			frame_alternation_signal_o  <= 1'b0;
			frame_alternation_signal_oe <= 1'b0;
			display_blank_signal_n_o    <= 1'b0;
			display_blank_signal_n_oe   <= 1'b0;
		end else begin
			display_clock_pin_o         <= clk_out_q;
			display_clock_pin_oe        <= primary && osc_on;
			frame_alternation_signal_o  <= fr_q;
			frame_alternation_signal_oe <= primary;
			display_blank_signal_n_o    <= ctrl_q[`CTRL_DISP_ON];
			display_blank_signal_n_oe   <= primary;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_low_oe             <= 1'b0;
			ram_read_enable         <= 1'b0;
			osc_enable              <= 1'b0;
			internal_divider_enable <= 1'b0;
			duty_mode               <= duty_33;
		end else begin
			// serial leaves low data lines undriven
			data_low_oe             <= par;
			ram_read_enable         <= par;
			osc_enable              <= osc_on;
			internal_divider_enable <= primary && int_div;
			duty_mode               <= duty;
		end
	end

	// static drive with indicator on in primary, following frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			static_indicator_drive <= 1'b0;
		end else begin
			static_indicator_drive <= primary && ctrl_q[`CTRL_STATIC_ON] && fr_q;
		end
	end

	// scan outputs depend only on shared timing, display enable and the segment pattern
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			segment_outputs          <= '0;
			common_outputs_lower     <= '0;
			common_outputs_upper     <= '0;
			indicator_common_outputs <= 2'b00;
		end else begin
			segment_outputs <= disp_en ?
				(segment_pattern ^ {`SEG_COUNT{fr_q}}) : '0;
			for (int i = 0; i < 32; i++) begin
				common_outputs_lower[i] <= disp_en &&
					(line_q == 7'(i)) && (line_q != last_line(duty));
				common_outputs_upper[i] <= disp_en &&
					(line_q == 7'(i + 32)) && (line_q != last_line(duty));
			end
			indicator_common_outputs <=
				{2{disp_en && (line_q == last_line(duty))}};
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence frame_edge_s;
		!primary && (fr_in != fr_in_d1_q);
	endsequence

	serial_hiz_a: assert property (!par ##1 !par |-> !data_low_oe)
		else $error("low data lines driven in serial mode");
	serial_noread_a: assert property (!par ##1 !par |-> !ram_read_enable)
		else $error("readback enabled in serial mode");
	frame_dir_a: assert property ($changed(primary) |=>
		frame_alternation_signal_oe == $past(primary))
		else $error("frame pin direction wrong");
	blank_dir_a: assert property (##1 display_blank_signal_n_oe
		== $past(primary))
		else $error("blank pin direction wrong");
	static_gate_a: assert property (!primary ##1 !primary |->
		!static_indicator_drive)
		else $error("static drive active in secondary");
	ind_pair_a: assert property (indicator_common_outputs[0]
		== indicator_common_outputs[1])
		else $error("indicator commons differ");
	div_gate_a: assert property (##1 internal_divider_enable ==
		$past(primary && int_div))
		else $error("divider enable wrong");
	osc_stop_a: assert property (!osc_on ##1 !osc_on |-> !clk_out_q)
		else $error("oscillator runs with strap low");
	frame_sync_a: assert property (frame_edge_s |=> line_q == 7'd0
		&& fr_q == $past(fr_in))
		else $error("secondary did not realign");
	line_bound_a: assert property (line_q <= last_line(duty))
		else $error("line index beyond duty");
endmodule : lcd_strap_sync

// file: hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 9
) (
	input  wire logic   aclk,
	input  wire logic   aresetn,
	pin_sync_if.syncer  pins
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] stable_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pins.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit moves only once two late stages agree, filtering glitches
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stable_q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					stable_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign pins.stable = stable_q;
endmodule : pin_sync

// file: shared/lcd_strap_params.svh
`ifndef LCD_STRAP_PARAMS_SVH
`define LCD_STRAP_PARAMS_SVH

// Register byte offsets
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_SCAN        12'h008

// Control register fields
`define CTRL_DISP_ON    0
`define CTRL_STATIC_ON  1
`define CTRL_RESET_VAL  32'h0000_0000

// Status register fields
`define ST_PARALLEL     0
`define ST_OSC_ON       1
`define ST_PRIMARY      2
`define ST_INT_DIV      3
`define ST_DUTY_LO      4
`define ST_DUTY_HI      5
`define ST_DISP_EN      6
`define ST_FRAME        7

// Scan register fields
`define SCAN_LINE_LSB   0
`define SCAN_FRAME_BIT  8

// Internal display clock, half period, derived from the 5 ns system clock
`define SYS_CLK_PERIOD_NS   5
`define DISP_CLK_HALF_NS    1000
`define DISP_CLK_HALF_CYC   ((`DISP_CLK_HALF_NS) / (`SYS_CLK_PERIOD_NS))

// Panel geometry
`define SEG_COUNT       132
`define COM_COUNT       64

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

// file: shared/lcd_strap_pkg.sv
package lcd_strap_pkg;
	typedef enum logic [1:0] {
		duty_33 = 2'b00,
		duty_49 = 2'b01,
		duty_55 = 2'b10,
		duty_65 = 2'b11
	} duty_t;

	typedef enum logic [1:0] {
		rd_idle = 2'b00,
		rd_resp = 2'b01
	} rd_state_t;

	typedef logic [6:0] line_t;
endpackage : lcd_strap_pkg

// file: shared/pin_sync_if.sv
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 9);
	logic [W-1:0] raw;
	logic [W-1:0] stable;
	modport syncer (input raw, output stable);
	modport user   (output raw, input stable);
endinterface : pin_sync_if

// file: tb/lcd_companion_model.sv
`timescale 1ns/1ps
module lcd_companion_model (
	input  wire logic run,
	output logic      clk_o,
	output logic      frame_o,
	output logic      blank_n_o
);
	initial begin
		clk_o = 1'b0;
		frame_o = 1'b0;
		blank_n_o = 1'b1;
		// Offset keeps pin edges clear of the system clock edges
		#1.3;
		forever begin
			if (!run) begin
				clk_o = 1'b0;
				#62.5;
			end else begin
				frame_o = ~frame_o;
				repeat (4) begin
					#62.5 clk_o = 1'b1;
					#62.5 clk_o = 1'b0;
				end
			end
		end
	end
endmodule : lcd_companion_model

// file: tb/lcd_strap_sync_test.sv
`timescale 1ns/1ps
`include "lcd_strap_params.svh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
	n_mismatch++; $display("Error %s expected %0h seen %0h", nm, exp, got); \
	end end
module lcd_strap_sync_test;
	import lcd_strap_pkg::*;
	logic         aclk, aresetn, run, comp_clk, comp_frame, comp_blank_n;
	logic [11:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, rsp, indicator_common_outputs;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready, parallel_select;
	logic         osc_source_select, primary_select, internal_divider_select;
	logic         duty_select_low, duty_select_high, display_clock_pin_i;
	logic         display_clock_pin_o, display_clock_pin_oe;
	logic         frame_alternation_signal_i, frame_alternation_signal_o;
	logic         frame_alternation_signal_oe, display_blank_signal_n_i;
	logic         display_blank_signal_n_o, display_blank_signal_n_oe;
	logic         data_low_oe, ram_read_enable, osc_enable;
	logic         internal_divider_enable, static_indicator_drive, lv;
	logic [131:0] segment_pattern, segment_outputs;
	logic [31:0]  common_outputs_lower, common_outputs_upper;
	duty_t        duty_mode;
	int           n_mismatch, samples_checked, n;

	// Shared pins: whoever enables drives, else the companion
	assign display_clock_pin_i = display_clock_pin_oe ?
		display_clock_pin_o : comp_clk;
	assign frame_alternation_signal_i = frame_alternation_signal_oe ?
		frame_alternation_signal_o : comp_frame;
	assign display_blank_signal_n_i = display_blank_signal_n_oe ?
		display_blank_signal_n_o : comp_blank_n;

	lcd_strap_sync dut (.*);
	lcd_companion_model comp (
		.run       (run),
		.clk_o     (comp_clk),
		.frame_o   (comp_frame),
		.blank_n_o (comp_blank_n)
	);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic tmo(input string nm);
		n_mismatch++;
		$display("Error timeout %s expected 1 seen 0", nm);
		summarize();
	endtask : tmo

	// Straps only change under reset, they are static while running
	task automatic setup(input logic p, o, m, dv, input logic [1:0] du);
		@(posedge aclk);
		aresetn <= 1'b0;
		parallel_select <= p;
		osc_source_select <= o;
		primary_select <= m;
		internal_divider_select <= dv;
		{duty_select_high, duty_select_low} <= du;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask : setup

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		if (!s_axi_bvalid) tmo("bvalid");
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [11:0] a);
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		if (!s_axi_rvalid) tmo("rvalid");
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr

	task automatic wait_for(input string nm, ref logic s, input logic v,
		input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
		if (s !== v) tmo(nm);
	endtask : wait_for

	initial begin
		{aresetn, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, parallel_select} = '0;
		{osc_source_select, primary_select, internal_divider_select} = '0;
		{duty_select_low, duty_select_high} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		segment_pattern = {33{4'hA}};
		n_mismatch = 0;
		samples_checked = 0;
		setup(1'b1, 1'b1, 1'b1, 1'b1, 2'b00);
		rdr(`OFF_CTRL);
		`CHK("ctrl reset", 32'h0000_0000, rd)
		`CHK("data low oe", 1'b1, data_low_oe)
		`CHK("readback", 1'b1, ram_read_enable)
		`CHK("osc", 1'b1, osc_enable)
		`CHK("divider", 1'b1, internal_divider_enable)
		`CHK("clk oe", 1'b1, display_clock_pin_oe)
		`CHK("frame oe", 1'b1, frame_alternation_signal_oe)
		`CHK("blank oe", 1'b1, display_blank_signal_n_oe)
		rdr(`OFF_STATUS);
		`CHK("status", 32'h0000_000F, rd & 32'h0000_003F)
		rdr(12'h00C);
		`CHK("unmapped resp", `RESP_DECERR, rsp)
		wr(12'h010, 32'h0000_0003);
		`CHK("unmapped wr", `RESP_DECERR, rsp)
		wr(`OFF_CTRL, 32'h0000_0003);
		`CHK("ctrl wr", `RESP_OKAY, rsp)
		wait_for("clk rise", display_clock_pin_o, 1'b1, 500);
		wait_for("clk fall", display_clock_pin_o, 1'b0, 500);
		`CHK("clk half", `DISP_CLK_HALF_CYC, n)
		`CHK("blank out", 1'b1, display_blank_signal_n_o)
		wait_for("frame hi", frame_alternation_signal_o, 1'b1, 40000);
		repeat (3) @(posedge aclk);
		`CHK("static hi", 1'b1, static_indicator_drive)
		wait_for("frame lo", frame_alternation_signal_o, 1'b0, 40000);
		repeat (3) @(posedge aclk);
		`CHK("static lo", 1'b0, static_indicator_drive)
		n = 0;
		while (indicator_common_outputs === 2'b00 && n < 40000) begin
			@(posedge aclk);
			n++;
		end
		if (indicator_common_outputs === 2'b00) tmo("ind com");
		`CHK("ind com", 2'b11, indicator_common_outputs)
		`CHK("com low", 32'h0000_0000, common_outputs_lower)
		`CHK("com up", 32'h0000_0000, common_outputs_upper)
		`CHK("seg", segment_pattern ^ {132{frame_alternation_signal_o}},
			segment_outputs)
		$display("test primary done");
		for (int i = 0; i < 4; i++) begin
			setup(1'b1, 1'b1, 1'b1, 1'b1, 2'(i));
			`CHK("duty", duty_t'(i), duty_mode)
			rdr(`OFF_STATUS);
			`CHK("duty status", 2'(i), rd[5:4])
		end
		$display("test duty done");
		setup(1'b0, 1'b0, 1'b0, 1'b1, 2'b00);
		wr(`OFF_CTRL, 32'h0000_0003);
		`CHK("data low oe", 1'b0, data_low_oe)
		`CHK("readback", 1'b0, ram_read_enable)
		`CHK("osc", 1'b0, osc_enable)
		`CHK("clk oe", 1'b0, display_clock_pin_oe)
		`CHK("frame oe", 1'b0, frame_alternation_signal_oe)
		`CHK("blank oe", 1'b0, display_blank_signal_n_oe)
		`CHK("divider", 1'b0, internal_divider_enable)
		`CHK("static", 1'b0, static_indicator_drive)
		run <= 1'b1;
		lv = comp_frame;
		wait_for("frame in", comp_frame, ~lv, 200);
		repeat (9) @(posedge aclk);
		`CHK("line zero", 32'h0000_0001, common_outputs_lower)
		`CHK("seg sec", segment_pattern ^ {132{comp_frame}},
			segment_outputs)
		rdr(`OFF_SCAN);
		`CHK("scan frame", 1'b1, rd[8])
		n = 0;
		while (common_outputs_lower !== 32'h0000_0002 && n < 60) begin
			@(posedge aclk);
			n++;
		end
		if (common_outputs_lower !== 32'h0000_0002) tmo("line one");
		`CHK("line one", 32'h0000_0002, common_outputs_lower)
		run <= 1'b0;
		$display("test secondary done");
		summarize();
	end
endmodule : lcd_strap_sync_test
